// [hw/usbef_pkg.sv]
package usbef_pkg;

   // register addresses on the plain register port
   localparam logic [7:0] ADDR_FUNC = 8'h48;
   localparam logic [7:0] ADDR_EP0_IRQ = 8'h49;
   localparam logic [7:0] ADDR_EP12_IRQ = 8'h4A;
   localparam logic [7:0] ADDR_EP0_CTRL = 8'h4B;
   localparam logic [7:0] ADDR_EP12_CTRL = 8'h4C;
   localparam logic [7:0] ADDR_EP0_BUF = 8'h20;
   localparam logic [7:0] ADDR_EP12_BUF = 8'h28;
   localparam logic [7:0] RESET_VAL = 8'h00;
   localparam int unsigned DOC_BUF_BYTES = 8;

   // function address register
   localparam int unsigned FA_EN = 7;
   // endpoint 0 flag register
   localparam int unsigned IF0_TX_FLAG = 7;
   localparam int unsigned IF0_RX_FLAG = 6;
   localparam int unsigned IF0_TX_IE = 5;
   localparam int unsigned IF0_RX_IE = 4;
   localparam int unsigned IF0_TX_CLR = 3;
   localparam int unsigned IF0_RX_CLR = 2;
   // endpoint 1/2 flag register
   localparam int unsigned IF12_TX_FLAG = 7;
   localparam int unsigned IF12_TX_IE = 5;
   localparam int unsigned IF12_TX_CLR = 3;
   // control registers; bit 6 is stall on ep0, target select on ep1/2
   localparam int unsigned CT_TOGGLE = 7;
   localparam int unsigned CT_STALL = 6;
   localparam int unsigned CT_SEL = 6;
   localparam int unsigned CT_TX_EN = 5;
   localparam int unsigned CT_RX_EN = 4;

   typedef enum logic [1:0] {
      PID_IN = 2'b00,
      PID_OUT = 2'b01,
      PID_SETUP = 2'b10
   } usbef_pid_e;

   typedef enum logic [1:0] {
      HS_NAK = 2'b00,
      HS_STALL = 2'b01,
      HS_DATA = 2'b10,
      HS_ACCEPT = 2'b11
   } usbef_hs_e;

   typedef struct packed {
      logic valid;
      usbef_pid_e pid;
      logic [6:0] addr;
      logic [3:0] ep;
   } usbef_tok_s;

   typedef struct packed {
      logic valid;
      logic [2:0] idx;
      logic [7:0] data;
   } usbef_rxb_s;

   typedef struct packed {
      logic valid;
      usbef_hs_e code;
      logic data1;
      logic [3:0] count;
   } usbef_resp_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } usbef_bus_s;

endpackage : usbef_pkg

// [hw/usbef_core.sv]
// The plain strobed port was decided locally.
`timescale 1ns/1ns
// What this block does
// - function inactive unless enable bit set
// - seven-bit function address, software written
// - ep0 transmit flag set on host ACK
// - ep0 transmit flag set NAKs IN
// - ep0 transmit flag cleared by write-one
// - ep0 receive flag set after ACKed packet
// - ep0 receive flag set NAKs OUT
// - ep0 receive clear bit write-one, stateless
// - ep0 transmit interrupt when flag and enable
// - ep0 receive interrupt when flag and enable
// - shared ep1/2 transmit flag on host ACK
// - shared flag set NAKs ep1/2 IN
// - shared flag cleared by write-one only
// - shared flag interrupt when enabled
// - toggle bit picks DATA1 or DATA0
// - stall bit stalls; SETUP clears it
// - ep0 IN NAK unless enabled, flag clear
// - ep0 OUT NAK unless enabled, flag clear
// - four-bit transmit byte count
// - eight-byte data buffers
// - ep1/2 IN NAK unless enabled, flag clear
// - target select NAKs wrong endpoint
module usbef_core #(
   parameter int unsigned BUF_BYTES = 8
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire usbef_pkg::usbef_bus_s i_bus,
   output logic [7:0] o_rdata,
   input wire usbef_pkg::usbef_tok_s i_tok,
   input wire logic i_host_ack,
   input wire logic i_rx_done,
   input wire usbef_pkg::usbef_rxb_s i_rx_byte,
   input wire logic [2:0] i_tx_idx,
   output logic [7:0] o_tx_data,
   output usbef_pkg::usbef_resp_s o_resp,
   output logic o_irq
);
   import usbef_pkg::*;

   initial begin
      if (BUF_BYTES == 0 || BUF_BYTES > DOC_BUF_BYTES) begin
         $error("BUF_BYTES must be 1 to 8");
      end
   end

   typedef struct packed {
      logic fn_en;
      logic [6:0] fn_addr;
      logic tx0_flag;
      logic rx0_flag;
      logic tx0_ie;
      logic rx0_ie;
      logic tx12_flag;
      logic tx12_ie;
      logic toggle0;
      logic stall0;
      logic tx0_en;
      logic rx0_en;
      logic [3:0] cnt0;
      logic toggle12;
      logic tgt_sel;
      logic tx12_en;
      logic [3:0] cnt12;
      logic pend_in0;
      logic pend_in12;
      logic pend_out0;
      logic [7:0][7:0] ep0_tx;
      logic [7:0][7:0] ep0_rx;
      logic [7:0][7:0] ep12_tx;
      logic [7:0] rdata;
      logic [7:0] tx_data;
      usbef_resp_s resp;
   } usbef_state_s;

   usbef_state_s q;
   usbef_state_s d;

   // buffer window decode, used for reads and writes
   function automatic logic buf_hit(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] off;
      off = addr - base;
      buf_hit = (addr >= base) && (off < 8'(BUF_BYTES));
   endfunction : buf_hit

   logic tok_mine;
   logic tok_ep0;
   logic tok_ep12;
   logic wr_if0;
   logic wr_if12;
   logic set_tx0;
   logic set_rx0;
   logic set_tx12;
   logic [2:0] bidx;

   assign tok_mine = i_tok.valid && q.fn_en && (i_tok.addr == q.fn_addr);
   assign tok_ep0 = tok_mine && (i_tok.ep == 4'h0);
   assign tok_ep12 = tok_mine && ((i_tok.ep == 4'h1) || (i_tok.ep == 4'h2));
   assign wr_if0 = i_bus.wr && (i_bus.addr == ADDR_EP0_IRQ);
   assign wr_if12 = i_bus.wr && (i_bus.addr == ADDR_EP12_IRQ);
   assign set_tx0 = q.pend_in0 && i_host_ack;
   assign set_rx0 = q.pend_out0 && i_rx_done;
   assign set_tx12 = q.pend_in12 && i_host_ack;
   assign bidx = i_bus.addr[2:0];

   always_comb begin
      d = q;
      d.resp = '0;
      d.rdata = RESET_VAL;
      d.tx_data = q.ep0_tx[i_tx_idx];

      // transaction outcome consumed by the first acknowledge or done
      if (i_host_ack) begin
         d.pend_in0 = 1'b0;
         d.pend_in12 = 1'b0;
      end
      if (i_rx_done) begin
         d.pend_out0 = 1'b0;
      end

      // receive bytes only land while an accepted OUT/SETUP is open
      if (i_rx_byte.valid && q.pend_out0 && (32'(i_rx_byte.idx) < BUF_BYTES)) begin
         d.ep0_rx[i_rx_byte.idx] = i_rx_byte.data;
      end

      // register writes
      if (i_bus.wr) begin
         if (i_bus.addr == ADDR_FUNC) begin
            d.fn_en = i_bus.wdata[FA_EN];
            d.fn_addr = i_bus.wdata[6:0];
         end else if (i_bus.addr == ADDR_EP0_IRQ) begin
            d.tx0_ie = i_bus.wdata[IF0_TX_IE];
            d.rx0_ie = i_bus.wdata[IF0_RX_IE];
         end else if (i_bus.addr == ADDR_EP12_IRQ) begin
            d.tx12_ie = i_bus.wdata[IF12_TX_IE];
         end else if (i_bus.addr == ADDR_EP0_CTRL) begin
            d.toggle0 = i_bus.wdata[CT_TOGGLE];
            d.stall0 = i_bus.wdata[CT_STALL];
            d.tx0_en = i_bus.wdata[CT_TX_EN];
            d.rx0_en = i_bus.wdata[CT_RX_EN];
            d.cnt0 = i_bus.wdata[3:0];
         end else if (i_bus.addr == ADDR_EP12_CTRL) begin
            d.toggle12 = i_bus.wdata[CT_TOGGLE];
            d.tgt_sel = i_bus.wdata[CT_SEL];
            d.tx12_en = i_bus.wdata[CT_TX_EN];
            d.cnt12 = i_bus.wdata[3:0];
         end else if (buf_hit(i_bus.addr, ADDR_EP0_BUF)) begin
            d.ep0_tx[bidx] = i_bus.wdata;
         end else if (buf_hit(i_bus.addr, ADDR_EP12_BUF)) begin
            d.ep12_tx[bidx] = i_bus.wdata;
         end
      end

      // register reads, answered next cycle
      if (i_bus.rd) begin
         if (i_bus.addr == ADDR_FUNC) begin
            d.rdata = {q.fn_en, q.fn_addr};
         end else if (i_bus.addr == ADDR_EP0_IRQ) begin
            // clear bits hold no state and read as zero
            d.rdata = RESET_VAL;
            d.rdata[IF0_TX_FLAG] = q.tx0_flag;
            d.rdata[IF0_RX_FLAG] = q.rx0_flag;
            d.rdata[IF0_TX_IE] = q.tx0_ie;
            d.rdata[IF0_RX_IE] = q.rx0_ie;
         end else if (i_bus.addr == ADDR_EP12_IRQ) begin
            d.rdata = RESET_VAL;
            d.rdata[IF12_TX_FLAG] = q.tx12_flag;
            d.rdata[IF12_TX_IE] = q.tx12_ie;
         end else if (i_bus.addr == ADDR_EP0_CTRL) begin
            d.rdata = {q.toggle0, q.stall0, q.tx0_en, q.rx0_en, q.cnt0};
         end else if (i_bus.addr == ADDR_EP12_CTRL) begin
            d.rdata = {q.toggle12, q.tgt_sel, q.tx12_en, 1'b0, q.cnt12};
         end else if (buf_hit(i_bus.addr, ADDR_EP0_BUF)) begin
            // ep0 buffer reads show received bytes
            d.rdata = q.ep0_rx[bidx];
         end
      end

      d.tx0_flag = (q.tx0_flag && !(wr_if0 && i_bus.wdata[IF0_TX_CLR])) || set_tx0;
      d.rx0_flag = (q.rx0_flag && !(wr_if0 && i_bus.wdata[IF0_RX_CLR])) || set_rx0;
      d.tx12_flag = (q.tx12_flag && !(wr_if12 && i_bus.wdata[IF12_TX_CLR])) || set_tx12;

      // token handling; a new token closes older transactions
      if (tok_ep0 || tok_ep12) begin
         d.pend_in0 = 1'b0;
         d.pend_in12 = 1'b0;
         d.pend_out0 = 1'b0;
         d.resp.valid = 1'b1;
         d.resp.code = HS_NAK;
      end
      if (tok_ep0) begin
         if (i_tok.pid == PID_SETUP) begin
            d.stall0 = 1'b0;
            d.resp.code = HS_ACCEPT;
            d.pend_out0 = 1'b1;
         end else if (q.stall0) begin
            d.resp.code = HS_STALL;
         end else if (i_tok.pid == PID_IN) begin
            if (q.tx0_en && !q.tx0_flag) begin
               d.resp.code = HS_DATA;
               d.resp.data1 = q.toggle0;
               d.resp.count = q.cnt0;
               d.pend_in0 = 1'b1;
            end
         end else if (i_tok.pid == PID_OUT) begin
            if (q.rx0_en && !q.rx0_flag) begin
               d.resp.code = HS_ACCEPT;
               d.pend_out0 = 1'b1;
            end
         end
      end
      if (tok_ep12 && (i_tok.pid == PID_IN)) begin
         if (q.tx12_en && !q.tx12_flag && ((i_tok.ep == 4'h2) == q.tgt_sel)) begin
            d.resp.code = HS_DATA;
            d.resp.data1 = q.toggle12;
            d.resp.count = q.cnt12;
            d.pend_in12 = 1'b1;
         end
      end

      // shared buffer drives the byte port while it owns the transfer
      if (q.pend_in12) begin
         d.tx_data = q.ep12_tx[i_tx_idx];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_rdata = q.rdata;
   assign o_tx_data = q.tx_data;
   assign o_resp = q.resp;
   assign o_irq = (q.tx0_flag && q.tx0_ie) || (q.rx0_flag && q.rx0_ie)
      || (q.tx12_flag && q.tx12_ie);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   AST_INACTIVE: assert property (i_tok.valid && !q.fn_en |=> !o_resp.valid)
      else $error("token answered while function disabled");
   AST_ADDR_MISS: assert property (i_tok.valid && (i_tok.addr != q.fn_addr) |=> !o_resp.valid)
      else $error("token for another address answered");
   AST_TX0_SET: assert property (q.pend_in0 && i_host_ack |=> q.tx0_flag)
      else $error("ep0 transmit flag not set after host ack");
   AST_TX0_NAK: assert property (tok_ep0 && i_tok.pid == PID_IN && !q.stall0
      && (q.tx0_flag || !q.tx0_en) |=> o_resp.valid && o_resp.code == HS_NAK)
      else $error("ep0 IN not refused");
   AST_RX0_NAK: assert property (tok_ep0 && i_tok.pid == PID_OUT && !q.stall0
      && (q.rx0_flag || !q.rx0_en) |=> o_resp.code == HS_NAK)
      else $error("ep0 OUT not refused");
   AST_CLR_TX0: assert property (wr_if0 && i_bus.wdata[IF0_TX_CLR] && !set_tx0 |=> !q.tx0_flag)
      else $error("ep0 transmit flag survived clear");
   AST_SET_WINS: assert property (wr_if0 && i_bus.wdata[IF0_RX_CLR] && set_rx0 |=> q.rx0_flag)
      else $error("receive event lost against clear");
   AST_STALL: assert property (tok_ep0 && i_tok.pid != PID_SETUP && q.stall0
      |=> o_resp.code == HS_STALL)
      else $error("stalled ep0 not stalling");
   AST_SETUP_CLR: assert property (tok_ep0 && i_tok.pid == PID_SETUP |=> !q.stall0
      && o_resp.code == HS_ACCEPT)
      else $error("SETUP did not clear stall");
   AST_DATA0_PID: assert property (tok_ep0 && i_tok.pid == PID_IN && !q.stall0 && q.tx0_en
      && !q.tx0_flag |=> o_resp.code == HS_DATA && o_resp.data1 == $past(q.toggle0)
      && o_resp.count == $past(q.cnt0))
      else $error("ep0 data packet id or count wrong");
   AST_EP2_SEL: assert property (tok_ep12 && i_tok.pid == PID_IN && i_tok.ep == 4'h2
      && !q.tgt_sel |=> o_resp.code == HS_NAK)
      else $error("ep2 served from ep1 buffer");
   AST_IRQ12: assert property (q.tx12_flag && q.tx12_ie |-> o_irq)
      else $error("shared flag interrupt missing");
   AST_RX0_SET: assert property (set_rx0 |=> q.rx0_flag)
      else $error("ep0 receive flag not set after good packet");
   AST_TX12_SET: assert property (set_tx12 |=> q.tx12_flag)
      else $error("shared transmit flag not set after host ack");
   AST_TX0_HOLD: assert property (q.tx0_flag && !(wr_if0 && i_bus.wdata[IF0_TX_CLR])
      |=> q.tx0_flag)
      else $error("ep0 transmit flag dropped without a clear");
   AST_TX0_NOSET: assert property (!q.tx0_flag && !set_tx0 |=> !q.tx0_flag)
      else $error("ep0 transmit flag set without a host ack");
   AST_CLR_RX0: assert property (wr_if0 && i_bus.wdata[IF0_RX_CLR] && !set_rx0
      |=> !q.rx0_flag)
      else $error("ep0 receive flag survived clear");
   AST_CLR_TX12: assert property (wr_if12 && i_bus.wdata[IF12_TX_CLR] && !set_tx12
      |=> !q.tx12_flag)
      else $error("shared transmit flag survived clear");
   AST_TX12_HOLD: assert property (q.tx12_flag && !(wr_if12 && i_bus.wdata[IF12_TX_CLR])
      |=> q.tx12_flag)
      else $error("shared transmit flag dropped without a clear");
   AST_TX12_NAK: assert property (tok_ep12 && i_tok.pid == PID_IN
      && (q.tx12_flag || !q.tx12_en) |=> o_resp.valid && o_resp.code == HS_NAK)
      else $error("ep1/2 IN not refused");
   AST_IRQ_TX0: assert property (q.tx0_flag && q.tx0_ie |-> o_irq)
      else $error("ep0 transmit interrupt missing");
   AST_IRQ_RX0: assert property (q.rx0_flag && q.rx0_ie |-> o_irq)
      else $error("ep0 receive interrupt missing");
   AST_IRQ_QUIET: assert property (!(q.tx0_flag && q.tx0_ie) && !(q.rx0_flag && q.rx0_ie)
      && !(q.tx12_flag && q.tx12_ie) |-> !o_irq)
      else $error("interrupt without an enabled flag");
   AST_TOGGLE_SW: assert property (!(i_bus.wr && i_bus.addr == ADDR_EP0_CTRL)
      |=> $stable(q.toggle0))
      else $error("ep0 toggle changed without software");
   AST_ADDR_HOLD: assert property (!(i_bus.wr && i_bus.addr == ADDR_FUNC)
      |=> $stable(q.fn_addr) && $stable(q.fn_en))
      else $error("function address changed without software");
   AST_RESP_ONCE: assert property (!(tok_ep0 || tok_ep12) |=> !o_resp.valid)
      else $error("response without a token for this function");

endmodule : usbef_core

// [verif/usbef_host.sv]
`timescale 1ns/1ns
module usbef_host (
   input wire logic i_clk,
   input wire usbef_pkg::usbef_resp_s i_resp,
   input wire logic [7:0] i_tx_data,
   output usbef_pkg::usbef_tok_s o_tok,
   output logic o_host_ack,
   output logic o_rx_done,
   output usbef_pkg::usbef_rxb_s o_rx_byte,
   output logic [2:0] o_tx_idx
);
   import usbef_pkg::*;
   initial begin
      o_tok = '0;
      o_host_ack = 1'b0;
      o_rx_done = 1'b0;
      o_rx_byte = '0;
      o_tx_idx = 3'h0;
   end
   // released token address and endpoint go inverted so a stale value is never reused
   task automatic token(input usbef_pid_e pid, input logic [6:0] a, input logic [3:0] ep,
         output usbef_resp_s resp);
      @(posedge i_clk);
      o_tok <= '{1'b1, pid, a, ep};
      @(posedge i_clk);
      o_tok <= '{1'b0, pid, ~a, ~ep};
      #1;
      resp = i_resp;
   endtask : token
   task automatic ack();
      @(posedge i_clk);
      o_host_ack <= 1'b1;
      @(posedge i_clk);
      o_host_ack <= 1'b0;
   endtask : ack
   task automatic rx(input logic [2:0] idx, input logic [7:0] d);
      @(posedge i_clk);
      o_rx_byte <= '{1'b1, idx, d};
      @(posedge i_clk);
      o_rx_byte <= '{1'b0, ~idx, ~d};
   endtask : rx
   task automatic rx_end();
      @(posedge i_clk);
      o_rx_done <= 1'b1;
      @(posedge i_clk);
      o_rx_done <= 1'b0;
   endtask : rx_end
   // buffer byte comes out registered one cycle after the index
   task automatic fetch(input logic [2:0] idx, output logic [7:0] d);
      @(posedge i_clk);
      o_tx_idx <= idx;
      @(posedge i_clk);
      #1;
      d = i_tx_data;
   endtask : fetch
endmodule : usbef_host

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   import usbef_pkg::*;
   localparam logic [6:0] A = 7'h15;
   localparam logic [7:0] REGS [6] = '{ADDR_FUNC, ADDR_EP0_IRQ, ADDR_EP12_IRQ,
      ADDR_EP0_CTRL, ADDR_EP12_CTRL, 8'h50};
   logic i_clk;
   logic i_rstn;
   usbef_bus_s bus;
   usbef_tok_s tok;
   usbef_rxb_s rxb;
   usbef_resp_s resp;
   logic [7:0] rdata, tx_data, d;
   logic [2:0] tx_idx;
   logic host_ack, rx_done, irq;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   usbef_core dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata),
      .i_tok(tok), .i_host_ack(host_ack), .i_rx_done(rx_done), .i_rx_byte(rxb),
      .i_tx_idx(tx_idx), .o_tx_data(tx_data), .o_resp(resp), .o_irq(irq));
   usbef_host host (.i_clk(i_clk), .i_resp(resp), .i_tx_data(tx_data), .o_tok(tok),
      .o_host_ack(host_ack), .o_rx_done(rx_done), .o_rx_byte(rxb), .o_tx_idx(tx_idx));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge i_clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_clk);
      bus.rd <= 1'b0;
      #1;
      chk("rdata", exp, rdata);
   endtask : rd
   function automatic logic [7:0] rs(usbef_hs_e c, logic d1, logic [3:0] n);
      return {1'b1, c, d1, n};
   endfunction : rs
   // only a data answer carries toggle and count
   task automatic tk(input usbef_pid_e p, input logic [6:0] a, input logic [3:0] ep,
         input logic [7:0] exp);
      usbef_resp_s r;
      logic [7:0] m;
      host.token(p, a, ep, r);
      m = !exp[7] ? 8'h80 : (exp[6:5] == HS_DATA ? 8'hFF : 8'hE0);
      chk("resp", exp, r & m);
   endtask : tk
   task automatic chk_irq(input logic e);
      #1;
      chk("irq", {7'h00, e}, {7'h00, irq});
   endtask : chk_irq
   initial begin
      bus = '0;
      i_rstn = 1'b0;
      repeat (20) @(posedge i_clk);
      i_rstn <= 1'b1;
      foreach (REGS[i]) rd(REGS[i], 8'h00);
      tk(PID_IN, 7'h00, 4'h0, 8'h00);
      wr(ADDR_FUNC, 8'h95);
      rd(ADDR_FUNC, 8'h95);
      tk(PID_IN, 7'h16, 4'h0, 8'h00);
      tk(PID_IN, A, 4'h0, rs(HS_NAK, 1'b0, 4'h0));
      for (int i = 0; i < 8; i++) wr(ADDR_EP0_BUF + 8'(i), 8'hC0 + 8'(i));
      for (int i = 0; i < 8; i++) begin
         host.fetch(3'(i), d);
         chk("tx_data", 8'hC0 + 8'(i), d);
      end
      wr(ADDR_EP0_CTRL, 8'hA5);
      tk(PID_IN, A, 4'h0, rs(HS_DATA, 1'b1, 4'h5));
      wr(ADDR_EP0_CTRL, 8'h23);
      tk(PID_IN, A, 4'h0, rs(HS_DATA, 1'b0, 4'h3));
      host.ack();
      rd(ADDR_EP0_IRQ, 8'h80);
      rd(ADDR_EP0_CTRL, 8'h23);
      tk(PID_IN, A, 4'h0, rs(HS_NAK, 1'b0, 4'h0));
      chk_irq(1'b0);
      wr(ADDR_EP0_IRQ, 8'h20);
      chk_irq(1'b1);
      wr(ADDR_EP0_IRQ, 8'hA0);
      rd(ADDR_EP0_IRQ, 8'hA0);
      wr(ADDR_EP0_IRQ, 8'h28);
      rd(ADDR_EP0_IRQ, 8'h20);
      chk_irq(1'b0);
      tk(PID_OUT, A, 4'h0, rs(HS_NAK, 1'b0, 4'h0));
      wr(ADDR_EP0_CTRL, 8'h10);
      tk(PID_OUT, A, 4'h0, rs(HS_ACCEPT, 1'b0, 4'h0));
      for (int i = 0; i < 8; i++) host.rx(3'(i), 8'h30 + 8'(i));
      host.rx_end();
      rd(ADDR_EP0_IRQ, 8'h60);
      for (int i = 0; i < 8; i++) rd(ADDR_EP0_BUF + 8'(i), 8'h30 + 8'(i));
      tk(PID_OUT, A, 4'h0, rs(HS_NAK, 1'b0, 4'h0));
      wr(ADDR_EP0_IRQ, 8'h10);
      chk_irq(1'b1);
      wr(ADDR_EP0_IRQ, 8'h14);
      rd(ADDR_EP0_IRQ, 8'h10);
      chk_irq(1'b0);
      tk(PID_OUT, A, 4'h0, rs(HS_ACCEPT, 1'b0, 4'h0));
      fork
         host.rx_end();
         wr(ADDR_EP0_IRQ, 8'h14);
      join
      rd(ADDR_EP0_IRQ, 8'h50);
      chk_irq(1'b1);
      wr(ADDR_EP0_IRQ, 8'h14);
      rd(ADDR_EP0_IRQ, 8'h10);
      wr(ADDR_EP0_CTRL, 8'h70);
      tk(PID_IN, A, 4'h0, rs(HS_STALL, 1'b0, 4'h0));
      tk(PID_OUT, A, 4'h0, rs(HS_STALL, 1'b0, 4'h0));
      tk(PID_SETUP, A, 4'h0, rs(HS_ACCEPT, 1'b0, 4'h0));
      rd(ADDR_EP0_CTRL, 8'h30);
      tk(PID_IN, A, 4'h1, rs(HS_NAK, 1'b0, 4'h0));
      wr(ADDR_EP12_CTRL, 8'h22);
      tk(PID_IN, A, 4'h1, rs(HS_DATA, 1'b0, 4'h2));
      tk(PID_IN, A, 4'h2, rs(HS_NAK, 1'b0, 4'h0));
      tk(PID_OUT, A, 4'h1, rs(HS_NAK, 1'b0, 4'h0));
      for (int i = 0; i < 8; i++) wr(ADDR_EP12_BUF + 8'(i), 8'h50 + 8'(i));
      rd(ADDR_EP12_BUF, 8'h00);
      wr(ADDR_EP12_CTRL, 8'hE2);
      rd(ADDR_EP12_CTRL, 8'hE2);
      tk(PID_IN, A, 4'h2, rs(HS_DATA, 1'b1, 4'h2));
      for (int i = 0; i < 8; i++) begin
         host.fetch(3'(i), d);
         chk("tx_data", 8'h50 + 8'(i), d);
      end
      host.ack();
      rd(ADDR_EP12_IRQ, 8'h80);
      tk(PID_IN, A, 4'h2, rs(HS_NAK, 1'b0, 4'h0));
      wr(ADDR_EP12_IRQ, 8'h80);
      rd(ADDR_EP12_IRQ, 8'h80);
      wr(ADDR_EP12_IRQ, 8'h20);
      chk_irq(1'b1);
      wr(ADDR_EP12_IRQ, 8'h28);
      rd(ADDR_EP12_IRQ, 8'h20);
      chk_irq(1'b0);
      wr(ADDR_FUNC, 8'h15);
      tk(PID_IN, A, 4'h2, 8'h00);
      test_done();
   end
endmodule : tb_top
